// ### hdl/supervisory_reset_watchdog.sv
// Supervisory reset generator with manual reset and watchdog
`timescale 1ns/100ps
module supervisory_reset_watchdog #(
  parameter int unsigned WD_CYCLES   =
    int'(supervisor_pkg::WD_CYCLES),
  parameter int unsigned HOLD_CYCLES =
    int'(supervisor_pkg::HOLD_CYCLES),
  parameter int unsigned MR_CYCLES   =
    int'(supervisor_pkg::MR_CYCLES),
  parameter bit          HAS_RESET_HIGH = 1'b1
) (
  input  wire logic REF_CLK_IN,
  input  wire logic RESET_N_IN,
  input  wire logic UNDERVOLTAGE_IN,
  input  wire logic MANUAL_RESET_N_IN,
  input  wire logic WATCHDOG_STROBE_IN,
  input  wire logic WATCHDOG_ENABLE_IN,
  output logic      RESET_N_OUT,
  output logic      RESET_OUT
);

  localparam int CW = supervisor_pkg::CNT_W;
  localparam int MW = supervisor_pkg::MR_W;

  // ==========================================================================
  // Input capture and strobe edge detect
  // ==========================================================================
  logic strobe_ff;
  logic nxt_strobe;
  logic strobe_edge;

  always_comb begin
    nxt_strobe  = WATCHDOG_STROBE_IN;
    strobe_edge = WATCHDOG_STROBE_IN != strobe_ff;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= nxt_strobe;
    end
  end

  // ==========================================================================
  // Manual reset qualification
  // ==========================================================================
  logic mr_done;

  // Counter restarts whenever the input is high, so short lows never qualify
  cycle_timer #(.W(MW)) u_mr_timer (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (RESET_N_IN),
    .clear_in (MANUAL_RESET_N_IN),
    .limit_in (MW'(MR_CYCLES - 2)),
    .done_out (mr_done)
  );

  // ==========================================================================
  // Watchdog timer
  // ==========================================================================
  logic wd_done;
  logic wd_clear;
  logic in_reset;

  assign wd_clear = strobe_edge || in_reset || !WATCHDOG_ENABLE_IN;

  cycle_timer #(.W(CW)) u_wd_timer (
    .clk_in   (REF_CLK_IN),
    .rst_n_in (RESET_N_IN),
    .clear_in (wd_clear),
    .limit_in (CW'(WD_CYCLES - 1)),
    .done_out (wd_done)
  );

  // ==========================================================================
  // Reset sequencer
  // ==========================================================================
  supervisor_pkg::sup_state_t state_ff;
  supervisor_pkg::sup_state_t nxt_state;
  logic [CW-1:0]              hold_ff;
  logic [CW-1:0]              nxt_hold;
  logic                       cause;
  logic                       wd_fire;
  logic                       nxt_rst;
  logic                       rst_ff;

  assign wd_fire = wd_done && WATCHDOG_ENABLE_IN && !in_reset;
  assign in_reset = state_ff != supervisor_pkg::ST_RUN;

  always_comb begin
    cause     = UNDERVOLTAGE_IN || mr_done;
    nxt_state = state_ff;
    nxt_hold  = hold_ff;
    case (state_ff)
      supervisor_pkg::ST_RESET: begin
        nxt_hold = '0;
        if (!cause) begin
          nxt_state = supervisor_pkg::ST_HOLD;
        end
      end
      supervisor_pkg::ST_HOLD: begin
        nxt_hold = hold_ff + CW'(1);
        if (cause) begin
          nxt_state = supervisor_pkg::ST_RESET;
        end else if (hold_ff >= CW'(HOLD_CYCLES - 2)) begin
          nxt_state = supervisor_pkg::ST_RUN;
        end
      end
      supervisor_pkg::ST_RUN: begin
        nxt_hold = '0;
        if (cause) begin
          nxt_state = supervisor_pkg::ST_RESET;
        end else if (wd_fire) begin
          nxt_state = supervisor_pkg::ST_HOLD;
        end
      end
      default: begin
        nxt_state = supervisor_pkg::ST_RESET;
      end
    endcase
    nxt_rst = nxt_state != supervisor_pkg::ST_RUN;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      state_ff <= supervisor_pkg::ST_RESET;
      hold_ff  <= '0;
      rst_ff   <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      hold_ff  <= nxt_hold;
      rst_ff   <= nxt_rst;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic rst_n_out_ff;
  logic rst_hi_out_ff;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      rst_n_out_ff  <= 1'b0;
      rst_hi_out_ff <= HAS_RESET_HIGH;
    end else begin
      rst_n_out_ff  <= !rst_ff;
      rst_hi_out_ff <= HAS_RESET_HIGH && rst_ff;
    end
  end

  assign RESET_N_OUT = rst_n_out_ff;
  assign RESET_OUT   = rst_hi_out_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_uv_asserts: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    UNDERVOLTAGE_IN |-> ##2 !RESET_N_OUT)
    else $error("Undervoltage did not assert reset");

  a_hold_full: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    $fell(rst_ff) |-> hold_ff == CW'(HOLD_CYCLES - 1))
    else $error("Reset released before hold period");

  a_wd_fire: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    wd_fire |=> state_ff == supervisor_pkg::ST_HOLD)
    else $error("Watchdog expiry did not start reset");

  a_edge_clears: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    strobe_edge && !in_reset |=> !wd_done)
    else $error("Strobe edge did not clear watchdog");

  // Consecutive manual-low samples, saturating at the qualification length
  logic [MW-1:0] mr_low_ff;
  logic [MW-1:0] nxt_mr_low;

  always_comb begin
    nxt_mr_low = mr_low_ff;
    if (MANUAL_RESET_N_IN) begin
      nxt_mr_low = '0;
    end else if (mr_low_ff < MW'(MR_CYCLES)) begin
      nxt_mr_low = mr_low_ff + MW'(1);
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      mr_low_ff <= '0;
    end else begin
      mr_low_ff <= nxt_mr_low;
    end
  end

  a_mr_qual: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    mr_low_ff == MW'(MR_CYCLES) |-> !RESET_N_OUT)
    else $error("Manual low did not assert reset");

  a_outs_pair: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    HAS_RESET_HIGH |-> RESET_OUT == !RESET_N_OUT)
    else $error("Reset outputs disagree");

  a_high_off: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    !HAS_RESET_HIGH |-> !RESET_OUT)
    else $error("Absent active-high output was driven");

  a_wd_held: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    in_reset |=> !wd_done)
    else $error("Watchdog counted during reset");

  a_wd_disable: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    !WATCHDOG_ENABLE_IN && !cause && state_ff == supervisor_pkg::ST_RUN
    |=> state_ff == supervisor_pkg::ST_RUN)
    else $error("Disabled watchdog fired");

  a_glitch_ign: assert property (@(posedge REF_CLK_IN)
    disable iff (!RESET_N_IN)
    $rose(mr_done) |->
    !$past(MANUAL_RESET_N_IN, int'(supervisor_pkg::GLITCH_CYCLES)))
    else $error("Short manual low accepted");

endmodule : supervisory_reset_watchdog

// ### pkg/supervisor_pkg.sv
// Constants and state encoding for the supervisory reset watchdog
package supervisor_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_PS   = 10000;

  // Watchdog period in milliseconds, nominal value
  localparam int unsigned WD_PERIOD_MS    = 1600;
  // Reset hold period in milliseconds, least value
  localparam int unsigned HOLD_PERIOD_MS  = 140;
  // Manual reset least low time in nanoseconds
  localparam int unsigned MR_QUAL_NS      = 1000;
  // Manual reset glitch rejection in nanoseconds
  localparam int unsigned MR_GLITCH_NS    = 100;
  // Least strobe pulse in nanoseconds
  localparam int unsigned STROBE_MIN_NS   = 50;

  localparam longint unsigned WD_CYCLES   =
    (64'(WD_PERIOD_MS) * 64'd1000000000) / 64'(CLK_PERIOD_PS);
  localparam longint unsigned HOLD_CYCLES =
    (64'(HOLD_PERIOD_MS) * 64'd1000000000 + 64'(CLK_PERIOD_PS) - 64'd1)
    / 64'(CLK_PERIOD_PS);
  // Qualification: low for longer than the glitch window, within 1 us
  localparam longint unsigned MR_CYCLES   =
    (64'(MR_QUAL_NS) * 64'd1000) / 64'(CLK_PERIOD_PS);
  localparam longint unsigned GLITCH_CYCLES =
    (64'(MR_GLITCH_NS) * 64'd1000) / 64'(CLK_PERIOD_PS);

  localparam int CNT_W = 28;
  localparam int MR_W  = 8;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_HOLD  = 2'b01,
    ST_RUN   = 2'b10
  } sup_state_t;

endpackage : supervisor_pkg

// ### hdl/cycle_timer.sv
// Saturating cycle counter with clear and expiry flag
`timescale 1ns/100ps
module cycle_timer #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         clear_in,
  input  wire logic [W-1:0] limit_in,
  output logic              done_out
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         done_ff;
  logic         nxt_done;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (clear_in) begin
      nxt_cnt = '0;
    end else if (cnt_ff < limit_in) begin
      nxt_cnt = cnt_ff + W'(1);
    end
    if (!clear_in && nxt_cnt >= limit_in) begin
      nxt_done = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done_out = done_ff;

endmodule : cycle_timer

// ### testbench/processor_model.sv
// Processor model that strobes the watchdog and receives reset
`timescale 1ns/100ps
module processor_model #(
  parameter int PERIOD = 20
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic active_in,
  output logic      strobe_out = 1'h0
);
  int unsigned count_ff = 0;

  // ==========================================================
  // Strobe program
  // ==========================================================
  // A reset restarts the program; a hung program leaves the strobe still
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      count_ff <= 0;
    end else if (active_in && count_ff >= PERIOD - 1) begin
      count_ff   <= 0;
      strobe_out <= ~strobe_out;
    end else begin
      count_ff <= count_ff + 1;
    end
  end
endmodule : processor_model

// ### testbench/test_supervisory_reset_watchdog.sv
// Self-checking bench for the supervisory reset watchdog
`timescale 1ns/100ps
module test_supervisory_reset_watchdog;
  localparam int WD   = 200;
  localparam int HOLD = 50;
  localparam int MR   = 100;
  localparam int TG   = 20;

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("BAD %0t reset output mismatch", $time); end end

  logic ref_clk = 1'h0;
  logic rst_n   = 1'h0;
  logic uv      = 1'h0;
  logic mr_n    = 1'h1;
  logic wd_en   = 1'h1;
  logic act     = 1'h1;
  logic strobe;
  logic rst_n_o;
  logic rst_o;
  logic rst_n_lo;
  logic rst_lo;
  int   mismatches = 0;
  int   compares   = 0;
  int   cycles     = 0;
  int   n;

  always #5 ref_clk = ~ref_clk;

  supervisory_reset_watchdog #(.WD_CYCLES(WD), .HOLD_CYCLES(HOLD),
    .MR_CYCLES(MR), .HAS_RESET_HIGH(1'h1)) supervisory_reset_watchdog_inst (
    .REF_CLK_IN         (ref_clk),
    .RESET_N_IN         (rst_n),
    .UNDERVOLTAGE_IN    (uv),
    .MANUAL_RESET_N_IN  (mr_n),
    .WATCHDOG_STROBE_IN (strobe),
    .WATCHDOG_ENABLE_IN (wd_en),
    .RESET_N_OUT        (rst_n_o),
    .RESET_OUT          (rst_o)
  );

  // Build without the active-high output
  supervisory_reset_watchdog #(.WD_CYCLES(WD), .HOLD_CYCLES(HOLD),
    .MR_CYCLES(MR), .HAS_RESET_HIGH(1'h0))
    supervisory_reset_watchdog_lo_inst (
    .REF_CLK_IN         (ref_clk),
    .RESET_N_IN         (rst_n),
    .UNDERVOLTAGE_IN    (uv),
    .MANUAL_RESET_N_IN  (mr_n),
    .WATCHDOG_STROBE_IN (strobe),
    .WATCHDOG_ENABLE_IN (wd_en),
    .RESET_N_OUT        (rst_n_lo),
    .RESET_OUT          (rst_lo)
  );

  processor_model #(.PERIOD(TG)) processor_model_inst (
    .clk_in     (ref_clk),
    .reset_n_in (rst_n_o),
    .active_in  (act),
    .strobe_out (strobe)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic go(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : go

  // Counts cycles until the active-low reset reaches the given level
  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (rst_n_o !== v && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask : wait_rst

  task automatic released;
    wait_rst(1'h1, HOLD + 20);
    `CHK(n inside {[HOLD - 3:HOLD + 4]}, 1'h1)
    `CHK(rst_o, 1'h0)
    `CHK(rst_lo, 1'h0)
    `CHK(rst_n_lo, rst_n_o)
  endtask : released

  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_power_on;
    `CHK(rst_n_o, 1'h0)
    `CHK(rst_o, 1'h1)
    @(posedge ref_clk) rst_n <= 1'h1;
    #1;
    released();
    $display("power-on test done");
  endtask : t_power_on

  task automatic t_undervoltage;
    @(posedge ref_clk) uv <= 1'h1;
    #1;
    wait_rst(1'h0, 6);
    `CHK(n inside {[1:3]}, 1'h1)
    `CHK(rst_o, 1'h1)
    `CHK(rst_lo, 1'h0)
    `CHK(rst_n_lo, 1'h0)
    go(30);
    `CHK(rst_n_o, 1'h0)
    @(posedge ref_clk) uv <= 1'h0;
    #1;
    released();
    $display("undervoltage test done");
  endtask : t_undervoltage

  task automatic t_manual;
    @(posedge ref_clk) mr_n <= 1'h0;
    go(8);
    @(posedge ref_clk) mr_n <= 1'h1;
    #1;
    wait_rst(1'h0, 20);
    `CHK(n, 20)
    @(posedge ref_clk) mr_n <= 1'h0;
    #1;
    wait_rst(1'h0, MR + 10);
    `CHK(n inside {[MR - 3:MR + 4]}, 1'h1)
    go(40);
    `CHK(rst_n_o, 1'h0)
    @(posedge ref_clk) mr_n <= 1'h1;
    #1;
    released();
    $display("manual reset test done");
  endtask : t_manual

  task automatic t_watchdog;
    wait_rst(1'h0, 3 * WD);
    `CHK(n, 3 * WD)
    @(posedge ref_clk) act <= 1'h0;
    #1;
    wait_rst(1'h0, WD + 20);
    `CHK(n inside {[WD - TG - 4:WD + 4]}, 1'h1)
    released();
    wait_rst(1'h0, WD + 20);
    `CHK(n inside {[WD - 3:WD + 4]}, 1'h1)
    released();
    $display("watchdog test done");
  endtask : t_watchdog

  task automatic t_disabled;
    @(posedge ref_clk) wd_en <= 1'h0;
    #1;
    wait_rst(1'h0, 2 * WD);
    `CHK(n, 2 * WD)
    $display("watchdog disable test done");
  endtask : t_disabled

  initial begin
    go(20);
    t_power_on();
    t_undervoltage();
    t_manual();
    t_watchdog();
    t_disabled();
    end_of_test();
  end
endmodule : test_supervisory_reset_watchdog
